// File: verilog/cdcrb_pkg.sv
// constants, field layouts and carrier types of the codec register bank
package cdcrb_pkg;
	// ----------------------------------------
	// direct register offsets
	// ----------------------------------------
	localparam logic [1:0] CDCRB_OFF_INDEX = 2'h0;
	localparam logic [1:0] CDCRB_OFF_DATA = 2'h1;
	localparam logic [1:0] CDCRB_OFF_STATUS = 2'h2;
	localparam logic [1:0] CDCRB_OFF_PIO = 2'h3;
	// ----------------------------------------
	// indirect register indices
	// ----------------------------------------
	localparam logic [4:0] CDCRB_IX_ADC_L = 5'h00;
	localparam logic [4:0] CDCRB_IX_WAVE_L = 5'h06;
	localparam logic [4:0] CDCRB_IX_FORMAT = 5'h08;
	localparam logic [4:0] CDCRB_IX_ERRSTAT = 5'h0b;
	localparam logic [4:0] CDCRB_IX_MODE = 5'h0c;
	localparam logic [4:0] CDCRB_IX_PB_HI = 5'h0e;
	localparam logic [4:0] CDCRB_IX_PB_LO = 5'h0f;
	localparam logic [4:0] CDCRB_IX_EXTACC = 5'h17;
	localparam logic [4:0] CDCRB_IX_ALTSTAT = 5'h18;
	localparam logic [4:0] CDCRB_IX_COMPAT = 5'h19;
	localparam logic [4:0] CDCRB_IX_MONO = 5'h1a;
	localparam logic [4:0] CDCRB_IX_RSVD_A = 5'h1b;
	localparam logic [4:0] CDCRB_IX_CAP_FMT = 5'h1c;
	localparam logic [4:0] CDCRB_IX_RSVD_B = 5'h1d;
	localparam logic [4:0] CDCRB_IX_CAP_HI = 5'h1e;
	localparam logic [4:0] CDCRB_IX_CAP_LO = 5'h1f;
	// ----------------------------------------
	// field positions and values
	// ----------------------------------------
	localparam int CDCRB_MODE_LSB = 5;
	localparam int CDCRB_MODE_FIXED_BIT = 7;
	localparam logic [7:0] CDCRB_MODE_WMASK = 8'h60;
	localparam logic [7:0] CDCRB_CAPFMT_WMASK = 8'hf0;
	localparam logic [7:0] CDCRB_REG_RESET = 8'h00;
	localparam int CDCRB_IDX_MCA_BIT = 6;
	localparam int CDCRB_IDX_TRD_BIT = 5;
	localparam int CDCRB_STAT_CAP_BIT = 5;
	localparam int CDCRB_STAT_ERR_BIT = 4;
	localparam int CDCRB_STAT_PB_BIT = 1;
	localparam int CDCRB_EXT_EN_BIT = 3;
	localparam int CDCRB_EXT_MSB_BIT = 2;
	// level steps in half-dB units
	localparam int CDCRB_ATTEN_STEP = 3;
	localparam int CDCRB_MONO_STEP = 6;
	localparam int CDCRB_WT_TOP = 24;
	// ----------------------------------------
	// modes and carrier
	// ----------------------------------------
	typedef enum logic [1:0] {
		CDCRB_MODE_ONE = 2'b00,
		CDCRB_MODE_RSV = 2'b01,
		CDCRB_MODE_TWO = 2'b10,
		CDCRB_MODE_THREE = 2'b11
	} cdcrb_mode_t;
	typedef struct packed {
		logic [1:0] sample_format_sel;
		logic companded;
		logic stereo;
		logic [2:0] clock_freq_sel;
		logic crystal_select;
	} cdcrb_fmt_t;
	typedef struct packed {
		logic mono_in_mute;
		logic mono_out_mute;
		logic mono_bypass;
		logic [3:0] mono_in_atten;
	} cdcrb_mono_t;
endpackage

// File: verilog/cdcrb_bank.sv
// indexed register bank of the audio codec, host pio side
`timescale 1ns/1ns
// Contract
// - decode four byte registers at base plus zero to three
// - five-bit index pointer selects one of 32 indirect registers via data port
// - offset 2 returns status, offset 3 moves audio samples by pio
// - after reset start in first mode, only indices 0 to 15 reachable
// - second or third mode opens indices 16 to 31
// - only third mode opens extended access through index 23
// - index 12 holds mode bits 6:5, constant one bit 7, revision 3:0
// - six-bit attenuations 1.5 dB steps from 0 dB; wavetable also from 0 dB
// - adc gain rises 1.5 dB steps; mono input falls 3 dB steps
// - index 8 format layout; index 28 repeats upper nibble for capture
// - index 23 forms five-bit extended pointer, bit 3 enables access
// - index 11 reports overrun, underrun, trim, request state, overrange
// - playback and capture base counts 16 bits as high/low byte pairs
// - index 26 holds mono mutes, bypass and four-bit mono attenuation
// - mode code 10 second, 11 third, 00 back to first
// - index bit 4 decoded only in second or higher mode
// - return to first mode clears capture format, capture count, alt status
module cdcrb_bank
	import cdcrb_pkg::*;
#(
	parameter logic [3:0] REVISION_ID = 4'h0, // arbitrary value
	parameter logic [7:0] COMPAT_ID = 8'h5a, // arbitrary value
	parameter int ADDR_W = 16
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic CODEC_ENABLE,
	input wire logic [ADDR_W-1:0] CODEC_IO_BASE,
	input wire logic [ADDR_W-1:0] IO_ADDR,
	input wire logic IO_AEN,
	input wire logic IO_RD_N,
	input wire logic IO_WR_N,
	input wire logic [7:0] IO_DATA_IN,
	output logic [7:0] IO_DATA_OUT,
	output logic IO_DATA_OE,
	input wire logic [7:0] ERR_STATUS_IN,
	input wire logic CAP_VALID,
	input wire logic [7:0] CAP_DATA,
	input wire logic PB_READY,
	output logic PB_VALID,
	output logic [7:0] PB_DATA,
	output logic [1:0] CODEC_MODE,
	output logic MODE_CHANGE_ALLOW,
	output logic TRANSFER_REQUEST_DISABLE,
	output logic [4:0] EXT_REG_POINTER,
	output logic EXT_REG_ACCESS_EN,
	output cdcrb_fmt_t PB_FORMAT,
	output cdcrb_fmt_t CAP_FORMAT,
	output cdcrb_mono_t MONO_CTRL,
	output logic [15:0] PB_BASE_COUNT,
	output logic [15:0] CAP_BASE_COUNT,
	output logic signed [7:0] WAVE_L_LEVEL,
	output logic signed [7:0] ADC_L_LEVEL,
	output logic signed [7:0] MONO_IN_LEVEL
);
	if (ADDR_W < 3 || ADDR_W > 16) begin : g_bad_addr_w
		$error("ADDR_W out of range");
	end
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] rd_s_r;
	logic [2:0] wr_s_r;
	logic [ADDR_W-1:0] addr_s1_r, addr_s2_r, addr_s3_r;
	logic [7:0] din_s1_r, din_s2_r, din_s3_r;
	logic aen_s1_r, aen_s2_r, aen_s3_r;
	logic rd_act_r;
	logic wr_act_r;
	always_ff @(posedge REF_CLK) begin
		rd_s_r <= {rd_s_r[1:0], ~IO_RD_N};
		wr_s_r <= {wr_s_r[1:0], ~IO_WR_N};
		addr_s1_r <= IO_ADDR;
		addr_s2_r <= addr_s1_r;
		addr_s3_r <= addr_s2_r;
		din_s1_r <= IO_DATA_IN;
		din_s2_r <= din_s1_r;
		din_s3_r <= din_s2_r;
		aen_s1_r <= IO_AEN;
		aen_s2_r <= aen_s1_r;
		aen_s3_r <= aen_s2_r;
	end
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			rd_act_r <= 1'b0;
			wr_act_r <= 1'b0;
		end else begin
			if (rd_s_r[1] == rd_s_r[2]) begin
				rd_act_r <= rd_s_r[2];
			end
			if (wr_s_r[1] == wr_s_r[2]) begin
				wr_act_r <= wr_s_r[2];
			end
		end
	end
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic rd_nxt;
	logic rd_start;
	logic rd_end;
	logic wr_end;
	logic hit;
	logic rd_hit_r;
	logic [1:0] rd_off_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic wr_aen_r;
	logic wr_commit;
	logic [1:0] wr_off;
	assign rd_nxt = (rd_s_r[1] == rd_s_r[2]) ? rd_s_r[2] : rd_act_r;
	assign rd_start = rd_nxt & ~rd_act_r;
	assign rd_end = ~rd_nxt & rd_act_r;
	assign wr_end = wr_act_r & (wr_s_r[1] == wr_s_r[2]) & ~wr_s_r[2];
	function automatic logic base_match(input logic [ADDR_W-1:0] a, input logic aen);
		base_match = CODEC_ENABLE & ~aen & (a[ADDR_W-1:2] == CODEC_IO_BASE[ADDR_W-1:2]);
	endfunction
	assign hit = base_match(addr_s3_r, aen_s3_r);
	assign wr_commit = wr_end & base_match(wr_addr_r, wr_aen_r);
	assign wr_off = wr_addr_r[1:0];
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wr_addr_r <= '0;
			wr_data_r <= CDCRB_REG_RESET;
			wr_aen_r <= 1'b1;
		end else if (wr_act_r) begin
			wr_addr_r <= addr_s3_r;
			wr_data_r <= din_s3_r;
			wr_aen_r <= aen_s3_r;
		end
	end
	// ----------------------------------------
	// index pointer and mode
	// ----------------------------------------
	logic [7:0] regs_r [0:31];
	logic [4:0] idx_r;
	logic mca_r;
	logic trd_r;
	logic [1:0] mode;
	logic mode2up;
	logic mode3;
	logic [4:0] eff_idx;
	assign mode = regs_r[CDCRB_IX_MODE][CDCRB_MODE_LSB +: 2];
	assign mode2up = (mode == CDCRB_MODE_TWO) || (mode == CDCRB_MODE_THREE);
	assign mode3 = (mode == CDCRB_MODE_THREE);
	assign eff_idx = {idx_r[4] & mode2up, idx_r[3:0]};
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			idx_r <= 5'h00;
			mca_r <= 1'b0;
			trd_r <= 1'b0;
		end else if (wr_commit && wr_off == CDCRB_OFF_INDEX) begin
			idx_r <= wr_data_r[4:0];
			mca_r <= wr_data_r[CDCRB_IDX_MCA_BIT];
			trd_r <= wr_data_r[CDCRB_IDX_TRD_BIT];
		end
	end
	// ----------------------------------------
	// indirect register file
	// ----------------------------------------
	logic ind_wr;
	logic [1:0] new_mode;
	logic drop_to_one;
	assign ind_wr = wr_commit && (wr_off == CDCRB_OFF_DATA);
	assign new_mode = wr_data_r[CDCRB_MODE_LSB +: 2];
	assign drop_to_one = ind_wr && eff_idx == CDCRB_IX_MODE && mode2up
		&& !(new_mode == CDCRB_MODE_TWO || new_mode == CDCRB_MODE_THREE);
	function automatic logic writable(input logic [4:0] ix, input logic m3);
		case (ix)
			CDCRB_IX_ERRSTAT, CDCRB_IX_COMPAT, CDCRB_IX_RSVD_A, CDCRB_IX_RSVD_B: begin
				writable = 1'b0;
			end
			CDCRB_IX_EXTACC: begin
				writable = m3;
			end
			default: begin
				writable = 1'b1;
			end
		endcase
	endfunction
	function automatic logic [7:0] wmask(input logic [4:0] ix);
		case (ix)
			CDCRB_IX_MODE: begin
				wmask = CDCRB_MODE_WMASK;
			end
			CDCRB_IX_CAP_FMT: begin
				wmask = CDCRB_CAPFMT_WMASK;
			end
			default: begin
				wmask = 8'hff;
			end
		endcase
	endfunction
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_reg
			always_ff @(posedge REF_CLK) begin
				if (SYS_RST) begin
					regs_r[gi] <= CDCRB_REG_RESET;
				end else if (gi == CDCRB_IX_ERRSTAT) begin
					regs_r[gi] <= ERR_STATUS_IN;
				end else if (drop_to_one && (gi == CDCRB_IX_CAP_FMT || gi == CDCRB_IX_CAP_HI
					|| gi == CDCRB_IX_CAP_LO || gi == CDCRB_IX_ALTSTAT)) begin
					regs_r[gi] <= CDCRB_REG_RESET;
				end else if (ind_wr && eff_idx == gi && writable(eff_idx, mode3)) begin
					regs_r[gi] <= wr_data_r & wmask(eff_idx);
				end
			end
		end
	endgenerate
	function automatic logic [7:0] ind_read(input logic [4:0] ix);
		case (ix)
			CDCRB_IX_MODE: begin
				ind_read = {1'b1, regs_r[ix][6:5], 1'b0, REVISION_ID};
			end
			CDCRB_IX_COMPAT: begin
				ind_read = COMPAT_ID;
			end
			CDCRB_IX_RSVD_A, CDCRB_IX_RSVD_B: begin
				ind_read = 8'h00;
			end
			CDCRB_IX_EXTACC: begin
				ind_read = mode3 ? regs_r[ix] : 8'h00;
			end
			default: begin
				ind_read = regs_r[ix];
			end
		endcase
	endfunction
	// ----------------------------------------
	// status and polled audio data
	// ----------------------------------------
	logic cap_avail_r;
	logic [7:0] cap_data_r;
	logic pb_free_r;
	logic serr_r;
	logic pio_rd_done;
	logic pio_wr;
	logic serr_set;
	assign pio_rd_done = rd_end && rd_hit_r && rd_off_r == CDCRB_OFF_PIO;
	assign pio_wr = wr_commit && wr_off == CDCRB_OFF_PIO;
	assign serr_set = (pio_rd_done && !cap_avail_r) || (pio_wr && !pb_free_r);
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			cap_avail_r <= 1'b0;
			cap_data_r <= 8'h00;
		end else if (CAP_VALID) begin
			cap_avail_r <= 1'b1;
			cap_data_r <= CAP_DATA;
		end else if (pio_rd_done) begin
			cap_avail_r <= 1'b0;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pb_free_r <= 1'b0;
		end else begin
			pb_free_r <= PB_READY;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			serr_r <= 1'b0;
		end else if (serr_set) begin
			serr_r <= 1'b1;
		end else if (wr_commit && wr_off == CDCRB_OFF_STATUS) begin
			serr_r <= 1'b0;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			PB_VALID <= 1'b0;
			PB_DATA <= 8'h00;
		end else begin
			PB_VALID <= pio_wr;
			if (pio_wr) begin
				PB_DATA <= wr_data_r;
			end
		end
	end
	// ----------------------------------------
	// host read path
	// ----------------------------------------
	function automatic logic [7:0] dir_read(input logic [1:0] off);
		logic [7:0] st;
		st = 8'h00;
		st[CDCRB_STAT_CAP_BIT] = cap_avail_r;
		st[CDCRB_STAT_ERR_BIT] = serr_r;
		st[CDCRB_STAT_PB_BIT] = pb_free_r;
		case (off)
			CDCRB_OFF_INDEX: begin
				dir_read = {1'b0, mca_r, trd_r, idx_r};
			end
			CDCRB_OFF_DATA: begin
				dir_read = ind_read(eff_idx);
			end
			CDCRB_OFF_STATUS: begin
				dir_read = st;
			end
			default: begin
				dir_read = cap_data_r;
			end
		endcase
	endfunction
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			IO_DATA_OUT <= 8'h00;
			IO_DATA_OE <= 1'b0;
			rd_hit_r <= 1'b0;
			rd_off_r <= 2'h0;
		end else if (rd_start) begin
			IO_DATA_OUT <= dir_read(addr_s3_r[1:0]);
			IO_DATA_OE <= hit;
			rd_hit_r <= hit;
			rd_off_r <= addr_s3_r[1:0];
		end else if (rd_end) begin
			IO_DATA_OE <= 1'b0;
			rd_hit_r <= 1'b0;
		end
	end
	// ----------------------------------------
	// decoded outputs
	// ----------------------------------------
	function automatic logic signed [7:0] lvl(input logic [5:0] code, input int step, input int top);
		lvl = 8'(top - step * int'(code));
	endfunction
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			CODEC_MODE <= CDCRB_MODE_ONE;
			MODE_CHANGE_ALLOW <= 1'b0;
			TRANSFER_REQUEST_DISABLE <= 1'b0;
			EXT_REG_POINTER <= 5'h00;
			EXT_REG_ACCESS_EN <= 1'b0;
			PB_FORMAT <= '0;
			CAP_FORMAT <= '0;
			MONO_CTRL <= '0;
			PB_BASE_COUNT <= 16'h0000;
			CAP_BASE_COUNT <= 16'h0000;
			WAVE_L_LEVEL <= 8'sh00;
			ADC_L_LEVEL <= 8'sh00;
			MONO_IN_LEVEL <= 8'sh00;
		end else begin
			CODEC_MODE <= mode;
			MODE_CHANGE_ALLOW <= mca_r;
			TRANSFER_REQUEST_DISABLE <= trd_r;
			EXT_REG_POINTER <= {regs_r[CDCRB_IX_EXTACC][CDCRB_EXT_MSB_BIT], regs_r[CDCRB_IX_EXTACC][7:4]};
			EXT_REG_ACCESS_EN <= mode3 & regs_r[CDCRB_IX_EXTACC][CDCRB_EXT_EN_BIT];
			PB_FORMAT <= regs_r[CDCRB_IX_FORMAT];
			CAP_FORMAT <= {regs_r[CDCRB_IX_CAP_FMT][7:4], regs_r[CDCRB_IX_FORMAT][3:0]};
			MONO_CTRL <= {regs_r[CDCRB_IX_MONO][7:5], regs_r[CDCRB_IX_MONO][3:0]};
			PB_BASE_COUNT <= {regs_r[CDCRB_IX_PB_HI], regs_r[CDCRB_IX_PB_LO]};
			CAP_BASE_COUNT <= {regs_r[CDCRB_IX_CAP_HI], regs_r[CDCRB_IX_CAP_LO]};
			WAVE_L_LEVEL <= lvl(regs_r[CDCRB_IX_WAVE_L][5:0], CDCRB_ATTEN_STEP, 0);
			ADC_L_LEVEL <= lvl({2'b00, regs_r[CDCRB_IX_ADC_L][3:0]}, -CDCRB_ATTEN_STEP, 0);
			MONO_IN_LEVEL <= lvl({2'b00, regs_r[CDCRB_IX_MONO][3:0]}, CDCRB_MONO_STEP, 0);
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	sequence seq_mode_drop;
		drop_to_one;
	endsequence
	sequence seq_capture_cleared;
		regs_r[CDCRB_IX_CAP_FMT] == 8'h00 && regs_r[CDCRB_IX_CAP_HI] == 8'h00
			&& regs_r[CDCRB_IX_CAP_LO] == 8'h00 && regs_r[CDCRB_IX_ALTSTAT] == 8'h00;
	endsequence
	chk_mode_drop_clear: assert property (seq_mode_drop |=> seq_capture_cleared)
		else $error("capture state kept after return to first mode");
	chk_low_idx_only: assert property (!mode2up |-> eff_idx[4] == 1'b0)
		else $error("upper index reached in first mode");
	chk_rsvd_zero: assert property (ind_read(CDCRB_IX_RSVD_A) == 8'h00 && ind_read(CDCRB_IX_RSVD_B) == 8'h00)
		else $error("reserved index not zero");
	chk_mode_id_byte: assert property ((ind_read(CDCRB_IX_MODE) & 8'h8f) == {1'b1, 3'b000, REVISION_ID})
		else $error("mode register fixed fields wrong");
	chk_compat_fixed: assert property (ind_wr && eff_idx == CDCRB_IX_COMPAT |=> ind_read(CDCRB_IX_COMPAT) == COMPAT_ID)
		else $error("identification byte changed");
	chk_ext_gate: assert property (!mode3 |=> !EXT_REG_ACCESS_EN)
		else $error("extended access open outside third mode");
	chk_read_drive: assert property (rd_start && hit |=> IO_DATA_OE ##0 IO_DATA_OUT == $past(dir_read(addr_s3_r[1:0])))
		else $error("read not driven");
	chk_pio_push: assert property (pio_wr |=> PB_VALID && PB_DATA == $past(wr_data_r))
		else $error("pio sample not passed");
	chk_cap_avail: assert property (CAP_VALID |=> cap_avail_r && cap_data_r == $past(CAP_DATA))
		else $error("capture sample lost");
	chk_index_store: assert property (wr_commit && wr_off == CDCRB_OFF_INDEX |=> idx_r == $past(wr_data_r[4:0]))
		else $error("index pointer not stored");
endmodule

// File: bench/cdcrb_isa_host.sv
// isa host model issuing pio cycles to the codec register bank
`timescale 1ns/1ns
module cdcrb_isa_host (
	input wire logic clk,
	output logic [15:0] io_addr,
	output logic io_aen,
	output logic io_rd_n,
	output logic io_wr_n,
	output logic [7:0] io_data_in,
	input wire logic [7:0] io_data_out,
	input wire logic io_data_oe
);
	initial begin
		io_addr = 16'h0000;
		io_aen = 1'h1;
		io_rd_n = 1'h1;
		io_wr_n = 1'h1;
		io_data_in = 8'h00;
	end
	// ----------------------------------------
	// one pio cycle, strobe held at least five clocks and, for a read, until answered, at most twelve
	// ----------------------------------------
	// caller hands data with reserved bits cleared
	task automatic cyc(input logic wr, input logic [15:0] addr, input logic [7:0] wd, output logic [7:0] rd,
		output logic seen);
		int n;
		begin
			rd = 8'h00;
			seen = wr;
			@(posedge clk);
			io_addr <= addr;
			io_aen <= 1'h0;
			io_data_in <= wd;
			repeat (4) @(posedge clk);
			if (wr) io_wr_n <= 1'h0;
			else io_rd_n <= 1'h0;
			for (n = 0; n < 12 && !(n >= 5 && seen); n++) begin
				@(posedge clk);
				if (!wr && !seen && io_data_oe === 1'h1) begin
					rd = io_data_out;
					seen = 1'h1;
				end
			end
			io_rd_n <= 1'h1;
			io_wr_n <= 1'h1;
			io_aen <= 1'h1;
			// released bus shows the inverse
			io_data_in <= ~wd;
			repeat (8) @(posedge clk);
		end
	endtask
endmodule

// File: bench/tb.sv
// self-checking bench of the codec register bank
`timescale 1ns/1ns
module tb;
	import cdcrb_pkg::*;
	localparam logic [15:0] BASE = 16'h0530;
	logic ref_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic enable = 1'h1;
	logic [15:0] io_addr;
	logic io_aen, io_rd_n, io_wr_n, oe, pb_valid, ext_en, mca, transfer_request_disable, seen;
	logic [7:0] io_din, io_dout, pb_data, pb_last, d, dv, fmt8, pbh, pbl, cd;
	logic [7:0] err_in = 8'h00;
	logic cap_valid = 1'h0;
	logic [7:0] cap_data = 8'h00;
	logic pb_ready = 1'h1;
	logic [1:0] mode;
	logic [4:0] ext_ptr;
	cdcrb_fmt_t pb_fmt, cap_fmt;
	cdcrb_mono_t mono;
	logic [15:0] pb_cnt, cap_cnt;
	logic [7:0] wave_lvl, adc_lvl, mono_lvl;
	logic [31:0] lf = 32'h0000_6834;
	int bad_count = 0;
	int checked = 0;
	int pulses = 0;
	int n;
	always #25 ref_clk = ~ref_clk;
	cdcrb_bank DUT (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CODEC_ENABLE(enable), .CODEC_IO_BASE(BASE),
		.IO_ADDR(io_addr), .IO_AEN(io_aen), .IO_RD_N(io_rd_n), .IO_WR_N(io_wr_n), .IO_DATA_IN(io_din),
		.IO_DATA_OUT(io_dout), .IO_DATA_OE(oe), .ERR_STATUS_IN(err_in), .CAP_VALID(cap_valid),
		.CAP_DATA(cap_data), .PB_READY(pb_ready), .PB_VALID(pb_valid), .PB_DATA(pb_data), .CODEC_MODE(mode),
		.MODE_CHANGE_ALLOW(mca), .TRANSFER_REQUEST_DISABLE(transfer_request_disable), .EXT_REG_POINTER(ext_ptr),
		.EXT_REG_ACCESS_EN(ext_en), .PB_FORMAT(pb_fmt), .CAP_FORMAT(cap_fmt), .MONO_CTRL(mono),
		.PB_BASE_COUNT(pb_cnt), .CAP_BASE_COUNT(cap_cnt), .WAVE_L_LEVEL(wave_lvl), .ADC_L_LEVEL(adc_lvl),
		.MONO_IN_LEVEL(mono_lvl));
	cdcrb_isa_host host (.clk(ref_clk), .io_addr(io_addr), .io_aen(io_aen), .io_rd_n(io_rd_n),
		.io_wr_n(io_wr_n), .io_data_in(io_din), .io_data_out(io_dout), .io_data_oe(oe));
	always @(posedge ref_clk) begin
		if (pb_valid === 1'h1) begin
			pulses <= pulses + 1;
			pb_last <= pb_data;
		end
	end
	// ----------------------------------------
	// expectations and checks
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// bits the host may use
	function automatic logic [7:0] rmask(input int ix);
		case (ix)
			0, 1, 12, 26: return 8'hef;
			4, 5, 9: return 8'hdf;
			10: return 8'hfe;
			13: return 8'hfd;
			default: return 8'hff;
		endcase
	endfunction
	function automatic logic [7:0] lvl(input int code, input int step);
		return 8'(code * step);
	endfunction
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: byte %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: word %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [1:0] off, input logic [7:0] v);
		logic [7:0] r;
		host.cyc(1'h1, BASE + {14'h0000, off}, v, r, seen);
	endtask
	task automatic rd(input logic [1:0] off, output logic [7:0] v);
		host.cyc(1'h0, BASE + {14'h0000, off}, 8'h00, v, seen);
		chk8({7'h00, seen}, 8'h01);
	endtask
	task automatic wi(input int ix, input logic [7:0] v);
		wr(CDCRB_OFF_INDEX, {3'h0, 5'(ix)});
		wr(CDCRB_OFF_DATA, v);
	endtask
	task automatic ri(input int ix, output logic [7:0] v);
		wr(CDCRB_OFF_INDEX, {3'h0, 5'(ix)});
		rd(CDCRB_OFF_DATA, v);
	endtask
	initial begin
		repeat (90000) @(posedge ref_clk);
		bad_count++;
		$display("ERROR %0t: run timeout", $time);
		tally_and_finish();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'h0;
		repeat (4) @(posedge ref_clk);
		ri(12, d);
		chk8(d & 8'hef, 8'h80);
		chk8({6'h00, mode}, 8'h00);
		wi(16, 8'h2b);
		ri(0, d);
		chk8(d & 8'hef, 8'h2b);
		chk8(adc_lvl, lvl(11, 3));
		wr(CDCRB_OFF_INDEX, 8'h6c);
		rd(CDCRB_OFF_INDEX, d);
		chk8(d, 8'h6c);
		chk8({6'h00, mca, transfer_request_disable}, 8'h03);
		$display("test first mode done");
		for (n = 0; n < 16; n++) begin
			if (n == 11 || n == 12) continue;
			lf = lfsr(lf);
			dv = lf[7:0] & rmask(n);
			wi(n, dv);
			ri(n, d);
			chk8(d & rmask(n), dv);
			if (n == 8) fmt8 = dv;
			if (n == 8) chk8(pb_fmt, dv);
			if (n == 14) pbh = dv;
			if (n == 15) pbl = dv;
		end
		chk16(pb_cnt, {pbh, pbl});
		foreach (cd[i]) begin
			wi(6, 8'(i * 6));
			chk8(wave_lvl, lvl(i * 6, -3));
		end
		err_in <= lf[15:8];
		ri(11, d);
		chk8(d, lf[15:8]);
		$display("test random bank done");
		@(posedge ref_clk);
		cap_valid <= 1'h1;
		cap_data <= lf[23:16];
		@(posedge ref_clk);
		cap_valid <= 1'h0;
		rd(CDCRB_OFF_STATUS, d);
		chk8(d & 8'h32, 8'h22);
		rd(CDCRB_OFF_PIO, d);
		chk8(d, lf[23:16]);
		rd(CDCRB_OFF_STATUS, d);
		chk8(d & 8'h32, 8'h02);
		rd(CDCRB_OFF_PIO, d);
		rd(CDCRB_OFF_STATUS, d);
		chk8(d & 8'h32, 8'h12);
		wr(CDCRB_OFF_STATUS, 8'h00);
		rd(CDCRB_OFF_STATUS, d);
		chk8(d & 8'h32, 8'h02);
		n = pulses;
		wr(CDCRB_OFF_PIO, lf[31:24]);
		chk16(16'(pulses - n), 16'h0001);
		chk8(pb_last, lf[31:24]);
		pb_ready <= 1'h0;
		wr(CDCRB_OFF_PIO, lf[7:0]);
		rd(CDCRB_OFF_STATUS, d);
		chk8(d & 8'h32, 8'h10);
		pb_ready <= 1'h1;
		wr(CDCRB_OFF_STATUS, 8'h00);
		host.cyc(1'h0, BASE + 16'h0004, 8'h00, d, seen);
		chk8({7'h00, seen}, 8'h00);
		enable <= 1'h0;
		host.cyc(1'h0, BASE, 8'h00, d, seen);
		chk8({7'h00, seen}, 8'h00);
		enable <= 1'h1;
		$display("test status and pio done");
		wi(12, 8'h40);
		ri(12, d);
		chk8(d & 8'hef, 8'hc0);
		chk8({6'h00, mode}, 8'h02);
		wi(26, 8'hcf);
		chk8({1'h0, mono}, 8'h6f);
		chk8(mono_lvl, lvl(15, -6));
		wi(28, 8'ha0);
		wi(30, pbl);
		wi(31, pbh);
		chk16(cap_cnt, {pbl, pbh});
		chk8(cap_fmt, {4'ha, fmt8[3:0]});
		wi(25, 8'h00);
		ri(25, d);
		chk8(d, 8'h5a);
		wi(27, 8'hff);
		wi(29, 8'hff);
		ri(27, d);
		chk8(d, 8'h00);
		ri(29, d);
		chk8(d, 8'h00);
		ri(26, d);
		chk8(d & 8'hef, 8'hcf);
		wi(23, 8'h5c);
		ri(23, d);
		chk8(d, 8'h00);
		chk8({7'h00, ext_en}, 8'h00);
		$display("test second mode done");
		wi(12, 8'h60);
		chk8({6'h00, mode}, 8'h03);
		wi(23, 8'h5c);
		ri(23, d);
		chk8(d & 8'hfc, 8'h5c);
		chk8({2'h0, ext_en, ext_ptr}, 8'h35);
		wi(12, 8'h00);
		chk8({5'h00, mode, ext_en}, 8'h00);
		chk16(cap_cnt, 16'h0000);
		chk8(cap_fmt, {4'h0, fmt8[3:0]});
		chk16(pb_cnt, {pbh, pbl});
		wi(12, 8'h20);
		chk8({6'h00, mode}, 8'h01);
		wi(17, 8'h2a);
		ri(1, d);
		chk8(d & 8'hef, 8'h2a);
		$display("test mode return done");
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'h0;
		repeat (4) @(posedge ref_clk);
		chk16(pb_cnt, 16'h0000);
		ri(0, d);
		chk8(d & 8'hef, 8'h00);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
